// ### shared/msfr_pkg.sv
// Package with types and constants for the MAC fragment reassembly block.
package msfr_pkg;

  // ******************************************
  // Widths and limits
  // ******************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BUF_DEPTH = 256;
  localparam int unsigned LEN_W = 9;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned SLOT_W = 2;
  localparam int unsigned FRAME_W = 5;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned TMO_W = 24;

  // ******************************************
  // Timing and field codes
  // ******************************************
  localparam logic [5:0] LEN_FRAG_START = 6'h3F;
  localparam logic [FRAME_W-1:0] FRAME_CTRL = 5'h12;
  localparam logic [FRAME_W-1:0] FRAME_FIRST_NORMAL = 5'h02;
  localparam logic [FRAME_W-1:0] FRAME_LAST_NORMAL = 5'h11;
  localparam logic [SLOT_W-1:0] SLOT_ONE = 2'h0;
  localparam logic [CNT_W-1:0] ABORT_COUNT_RST = 8'h03;
  localparam int unsigned TIMEOUT_US = 100;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam logic [LEN_W-1:0] LEN_ZERO = 9'h000;

  // ******************************************
  // PDU kinds
  // ******************************************
  typedef enum logic [2:0]
  {
    MSFR_PDU_ACCESS = 3'h0,
    MSFR_PDU_DATA = 3'h1,
    MSFR_PDU_FRAG = 3'h2,
    MSFR_PDU_END = 3'h3,
    MSFR_PDU_ENDHU = 3'h4,
    MSFR_PDU_RESOURCE = 3'h5,
    MSFR_PDU_OTHER = 3'h6
  } msfr_kind_t;

  // Header of one received PDU, presented with its first payload beat.
  typedef struct packed
  {
    msfr_kind_t kind;
    logic fragStart;
    logic [5:0] lenInd;
    logic [ADDR_W-1:0] addr;
    logic ownAddr;
    logic granted;
    logic subslot;
    logic [SLOT_W-1:0] slot;
    logic [FRAME_W-1:0] frame;
  } msfr_hdr_t;

  // Station mode settings.
  typedef struct packed
  {
    logic downlink;
    logic minMode;
    logic commonCtrl;
    logic timeShared;
    logic reservedFrame;
    logic [SLOT_W-1:0] mySlot;
    logic [SLOT_W-1:0] tsSlot;
  } msfr_mode_t;

  // Reassembly states.
  typedef enum logic [2:0]
  {
    MSFR_IDLE = 3'b001,
    MSFR_COLLECT = 3'b010,
    MSFR_BLOCKED = 3'b100
  } msfr_state_t;

endpackage : msfr_pkg

// ### verilog/msfr_sync.sv
// Two-stage synchroniser for a level input from a pin.
`timescale 1ns/100ps
module msfr_sync
  import msfr_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Data.
  input wire logic asyncIn,
  output logic syncOut
);

  typedef struct packed
  {
    logic stage1;
    logic stage2;
  } msfr_sync_t;

  msfr_sync_t st_reg;
  msfr_sync_t st_next;

  // The first stage is read only by the second, to contain metastability.
  always_comb
  begin
    st_next.stage1 = asyncIn;
    st_next.stage2 = st_reg.stage1;
  end

  // Registers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign syncOut = st_reg.stage2;

endmodule : msfr_sync

// ### verilog/msfr_buf.sv
// Byte store holding a fragmented SDU until it is complete.
`timescale 1ns/100ps
module msfr_buf
  import msfr_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Write side.
  input wire logic wrEn,
  input wire logic [LEN_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read side.
  input wire logic [LEN_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] mem [BUF_DEPTH];

  typedef struct packed
  {
    logic [DATA_W-1:0] q;
  } msfr_buf_t;

  msfr_buf_t st_reg;
  msfr_buf_t st_next;

  // Read is registered, one cycle of latency.
  always_comb
  begin
    st_next.q = mem[rdAddr[7:0]];
  end

  // Memory write has no reset; contents are meaningless until written.
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
      mem[wrAddr[7:0]] <= wrData;
  end

  // Registers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rdData = st_reg.q;

endmodule : msfr_buf

// ### verilog/msfr_reassembly.sv
// Reassembly engine for fragmented MAC signalling SDUs.
`timescale 1ns/100ps
// Overview of operation
// [R1] Start PDU without fragmentation marker delivers its SDU whole.
// [R2] Fragment start with grant stores the fragment and watches granted slots.
// [R3] Granted final subslot: only its first PDU is examined.
// [R4] End-with-header PDU in that subslot appends and completes the SDU.
// [R5] Access PDU in that subslot drops the store, then is processed anew.
// [R6] Undecodable final subslot drops the stored fragment.
// [R7] Frag PDU in a granted slot appends and keeps watching.
// [R8] End PDU appends and completes, even when empty.
// [R9] Data PDU during reassembly discards partial SDU, then is processed.
// [R10] Decode failure in a granted slot discards the partial SDU.
// [R11] After decode failure, frag and end PDUs drop until access or data.
// [R12] No grant, no wait order, timeout elapsed: discard partial SDU.
// [R13] Continuation PDUs without pending start are discarded.
// [R14] Minimum mode: continuation only in designated frame-18 slot.
// [R15] Minimum mode: discard on decode failure or N missed frame-18 slots.
// [R16] Leaving minimum mode restores search of all control channel slots.
// [R17] Minimum mode still hears slot 1 of frames 2..17; starts abort.
// [R18] Slot restriction only in common control mode on main channel.
// [R19] Time-shared: continuation only in slot 1 of reserved frames.
// [R20] Time-shared: discard on decode failure or N missed reserved slots.
// [R21] Time-shared: common frame slot still heard; secondary uses given slot.
// [R22] All of a mobile's identities count as one address.
// [R23] All-ones length code marks start of fragmentation on downlink.
// [R24] Buffer up to a maximum length and release only complete SDUs.
// [R25] Abort count and timeout are configurable parameters.
module msfr_reassembly
  import msfr_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [CNT_W-1:0] ABORT_COUNT = ABORT_COUNT_RST
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Received PDU stream, one byte per beat.
  input wire logic pduValid,
  input wire logic pduFirst,
  input wire logic pduLast,
  input wire msfr_hdr_t pduHdr,
  input wire logic [DATA_W-1:0] pduData,
  input wire logic pduHasData,
  // Slot events.
  input wire logic slotTick,
  input wire msfr_hdr_t slotInfo,
  input wire logic decodeFail,
  input wire logic grantIssued,
  input wire logic waitIssued,
  input wire logic grantCapacity,
  // Mode pin, asynchronous.
  input wire logic minModePin,
  input wire msfr_mode_t modeCfg,
  // Delivered SDU stream.
  output logic sduValid,
  output logic [DATA_W-1:0] sduData,
  output logic sduLast,
  output logic sduDiscard,
  output logic busy
);

  localparam logic [TMO_W-1:0] TMO_LOAD = TMO_W'(TIMEOUT_CYCLES);
  localparam logic [LEN_W-1:0] MAX_LEN = LEN_W'(BUF_DEPTH);

  // ******************************************
  // Helper functions
  // ******************************************

  // A slot may carry continuation for us given the current mode.
  function automatic logic slotWatched(input msfr_mode_t m, input logic minMd, input msfr_hdr_t s);
    logic ok;
    ok = 1'b1;
    if (!m.downlink)
      ok = s.granted; // see [R2]
    else if (minMd && m.commonCtrl)
      ok = (s.frame == FRAME_CTRL) && (s.slot == m.mySlot); // see [R14] see [R18]
    else if (m.timeShared)
      ok = m.reservedFrame && (s.slot == m.tsSlot); // see [R19] see [R21]
    return ok;
  endfunction : slotWatched

  // A PDU is a start of fragmentation.
  function automatic logic isStart(input logic dl, input msfr_hdr_t h);
    logic r;
    if (dl)
      r = (h.kind == MSFR_PDU_RESOURCE) && (h.lenInd == LEN_FRAG_START); // see [R23]
    else
      r = ((h.kind == MSFR_PDU_ACCESS) || (h.kind == MSFR_PDU_DATA)) && h.fragStart;
    return r;
  endfunction : isStart

  // ******************************************
  // State
  // ******************************************
  typedef struct packed
  {
    msfr_state_t state;
    logic finalSub;
    logic subSeen;
    logic [ADDR_W-1:0] owner;
    logic [LEN_W-1:0] wrPtr;
    logic [LEN_W-1:0] rdPtr;
    logic [LEN_W-1:0] sduLen;
    logic draining;
    logic rdValid;
    logic rdLast;
    logic drainPend;
    logic capture;
    logic wasMin;
    logic [CNT_W-1:0] missCnt;
    logic [TMO_W-1:0] tmo;
    logic sduValid;
    logic [DATA_W-1:0] sduData;
    logic sduLast;
    logic sduDiscard;
    logic busy;
  } msfr_state_s_t;

  msfr_state_s_t st_reg;
  msfr_state_s_t st_next;
  logic minMode;
  logic bufWr;
  logic [LEN_W-1:0] wrBase;
  logic [DATA_W-1:0] bufQ;
  logic hdrBeat;
  logic startPdu;
  logic contPdu;
  logic ownPdu;

  // Minimum-mode pin arrives from another domain.
  msfr_sync u_sync
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn(minModePin),
    .syncOut(minMode)
  );

  // SDU store.
  msfr_buf u_buf
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wrEn(bufWr),
    .wrAddr(wrBase),
    .wrData(pduData),
    .rdAddr(st_reg.rdPtr),
    .rdData(bufQ)
  );

  // Header classification; ownAddr already merges all identities. see [R22]
  always_comb
  begin
    hdrBeat = pduValid && pduFirst;
    startPdu = isStart(modeCfg.downlink, pduHdr);
    contPdu = (pduHdr.kind == MSFR_PDU_FRAG) || (pduHdr.kind == MSFR_PDU_END) || (pduHdr.kind == MSFR_PDU_ENDHU);
    ownPdu = pduHdr.ownAddr;
  end

  // ******************************************
  // Next state
  // ******************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.sduValid = 1'b0;
    st_next.sduLast = 1'b0;
    st_next.sduDiscard = 1'b0;
    st_next.wasMin = minMode;
    if (st_reg.tmo != '0)
      st_next.tmo = st_reg.tmo - 1'b1;
    // Leaving minimum mode resets the frame-18 miss count. see [R16]
    if (st_reg.wasMin && !minMode)
      st_next.missCnt = '0;

    // Header beat decisions.
    if (hdrBeat)
    begin
      st_next.capture = 1'b0;
      if (startPdu && ownPdu)
      begin
        // A new start aborts whatever was held, then is handled anew. see [R5] see [R9]
        if (st_reg.state == MSFR_COLLECT)
          st_next.sduDiscard = 1'b1;
        st_next.wrPtr = '0;
        st_next.capture = 1'b1;
        st_next.owner = pduHdr.addr;
        st_next.missCnt = '0;
        st_next.subSeen = 1'b0;
        st_next.finalSub = pduHdr.subslot;
        st_next.tmo = TMO_LOAD;
        st_next.state = (modeCfg.downlink || grantCapacity) ? MSFR_COLLECT : MSFR_IDLE; // see [R2]
        if (!modeCfg.downlink && !grantCapacity)
          st_next.capture = 1'b0;
      end
      else if (startPdu && modeCfg.downlink && st_reg.state == MSFR_COLLECT)
      begin
        // On downlink, any other station's start also aborts. see [R17]
        st_next.state = MSFR_IDLE;
        st_next.sduDiscard = 1'b1;
      end
      else if (!startPdu && ownPdu && (pduHdr.kind != MSFR_PDU_FRAG) && !contPdu)
      begin
        // Unfragmented SDU passes straight through the store. see [R1]
        // Access or data PDU from the mobile ends any partial SDU first.
        if ((pduHdr.kind == MSFR_PDU_DATA || pduHdr.kind == MSFR_PDU_ACCESS) && st_reg.state == MSFR_COLLECT)
          st_next.sduDiscard = 1'b1; // see [R5] see [R9]
        st_next.state = MSFR_IDLE;
        st_next.wrPtr = '0;
        st_next.capture = 1'b1;
        st_next.drainPend = 1'b1;
      end
      else if (contPdu && ownPdu)
      begin
        if (st_reg.state != MSFR_COLLECT || !slotWatched(modeCfg, minMode, pduHdr))
          st_next.capture = 1'b0; // see [R11] see [R13]
        else if (st_reg.finalSub && st_reg.subSeen)
          st_next.capture = 1'b0; // see [R3]
        else if (st_reg.finalSub && pduHdr.kind != MSFR_PDU_ENDHU)
        begin
          st_next.state = MSFR_IDLE; // see [R3]
          st_next.sduDiscard = 1'b1;
        end
        else
        begin
          st_next.capture = 1'b1; // see [R4] see [R7] see [R8]
          st_next.subSeen = 1'b1;
          st_next.missCnt = '0;
          st_next.tmo = TMO_LOAD;
          if (pduHdr.kind != MSFR_PDU_FRAG)
            st_next.drainPend = 1'b1;
        end
      end
    end

    // Write at the pointer the header beat left, so a restart's first byte lands at zero. see [R24]
    // The write is decided before completion, so the last byte of a PDU is kept too.
    wrBase = st_next.wrPtr;
    bufWr = pduValid && st_next.capture && pduHasData && (wrBase < MAX_LEN);
    if (bufWr)
      st_next.wrPtr = wrBase + 1'b1;

    // Completion at the PDU end starts a drain; an empty SDU has nothing to drain.
    if (pduValid && pduLast && st_next.drainPend)
    begin
      st_next.drainPend = 1'b0;
      st_next.capture = 1'b0;
      st_next.draining = (st_next.wrPtr != LEN_ZERO);
      st_next.sduLen = st_next.wrPtr;
      st_next.rdPtr = '0;
      st_next.state = MSFR_IDLE;
    end

    // Slot-level abort conditions.
    if (slotTick && st_reg.state == MSFR_COLLECT && slotWatched(modeCfg, minMode, slotInfo))
    begin
      if (decodeFail)
      begin
        st_next.sduDiscard = 1'b1; // see [R6] see [R10] see [R15] see [R20]
        st_next.state = modeCfg.downlink ? MSFR_IDLE : MSFR_BLOCKED; // see [R11]
      end
      else if (modeCfg.downlink && (st_reg.missCnt + 1'b1 >= ABORT_COUNT))
      begin
        st_next.sduDiscard = 1'b1; // see [R15] see [R20] see [R25]
        st_next.state = MSFR_IDLE;
      end
      else if (modeCfg.downlink)
        st_next.missCnt = st_reg.missCnt + 1'b1;
    end

    // Uplink inactivity timeout. see [R12] see [R25]
    if (!modeCfg.downlink && st_reg.state == MSFR_COLLECT)
    begin
      if (grantIssued || waitIssued)
        st_next.tmo = TMO_LOAD;
      else if (st_reg.tmo == 1)
      begin
        st_next.sduDiscard = 1'b1;
        st_next.state = MSFR_IDLE;
      end
    end

    // Drain the complete SDU; the store's read takes a cycle, so each read is flagged
    // and becomes an output byte one edge later, the last one marked. see [R24]
    st_next.rdValid = st_reg.draining;
    st_next.rdLast = st_reg.draining && (st_reg.rdPtr + 1'b1 >= st_reg.sduLen);
    if (st_reg.draining)
    begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
      if (st_reg.rdPtr + 1'b1 >= st_reg.sduLen)
        st_next.draining = 1'b0;
    end
    st_next.sduValid = st_reg.rdValid;
    st_next.sduLast = st_reg.rdLast;
    st_next.sduData = bufQ;
    st_next.busy = (st_next.state == MSFR_COLLECT) || st_next.draining || st_next.rdValid;
  end

  // Registers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.state <= MSFR_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // Outputs come straight from flops.
  assign sduValid = st_reg.sduValid;
  assign sduData = st_reg.sduData;
  assign sduLast = st_reg.sduLast;
  assign sduDiscard = st_reg.sduDiscard;
  assign busy = st_reg.busy;

  // ******************************************
  // Checks
  // ******************************************
  chk_decode_fail_discard: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R10]
    (slotTick && decodeFail && st_reg.state == MSFR_COLLECT && slotWatched(modeCfg, minMode, slotInfo))
    |=> sduDiscard)
    else $error("Decode failure did not discard.");
  chk_blocked_after_fail: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R11]
    (st_reg.state == MSFR_BLOCKED && hdrBeat && contPdu) |=> !st_reg.capture)
    else $error("Fragment taken while blocked.");
  chk_orphan_dropped: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R13]
    (st_reg.state == MSFR_IDLE && hdrBeat && contPdu) |=> !st_reg.capture)
    else $error("Orphan continuation captured.");
  chk_no_release_early: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R24]
    (st_reg.state == MSFR_COLLECT && !st_reg.draining) |=> !sduValid)
    else $error("Data released before completion.");
  chk_start_collects: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R2]
    (hdrBeat && startPdu && ownPdu && !modeCfg.downlink && grantCapacity) |=> st_reg.state == MSFR_COLLECT)
    else $error("Start fragment not stored.");
  chk_data_aborts: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R9]
    (hdrBeat && ownPdu && pduHdr.kind == MSFR_PDU_DATA && !startPdu && st_reg.state == MSFR_COLLECT)
    |=> sduDiscard)
    else $error("Data PDU did not abort.");
  chk_minmode_slot: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R14]
    (hdrBeat && contPdu && modeCfg.downlink && minMode && modeCfg.commonCtrl && pduHdr.frame != FRAME_CTRL)
    |=> !st_reg.capture)
    else $error("Fragment taken outside frame 18.");
  chk_timeout_discard: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R12]
    (!modeCfg.downlink && st_reg.state == MSFR_COLLECT && st_reg.tmo == 1 && !grantIssued && !waitIssued)
    |=> sduDiscard)
    else $error("Timeout did not discard.");

endmodule : msfr_reassembly

// ### verif/msfr_peer.sv
// Peer station model that sends PDUs to the reassembly block.
`timescale 1ns/100ps
module msfr_peer
  import msfr_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // PDU stream towards the block.
  output logic pduValid,
  output logic pduFirst,
  output logic pduLast,
  output msfr_hdr_t pduHdr,
  output logic [DATA_W-1:0] pduData,
  output logic pduHasData
);
  // ********************
  // Idle lines
  // ********************
  // All strobes start low so nothing is taken before the first request.
  initial
  begin
    pduValid = 1'b0;
    pduFirst = 1'b0;
    pduLast = 1'b0;
    pduHdr = '0;
    pduData = 8'h00;
    pduHasData = 1'b0;
  end

  // ********************
  // PDU sender
  // ********************
  // The header rides with the first beat; an empty PDU is one beat without a byte.
  // After release the strobes drop and the header and data lines show inverted values, so a stale byte never passes for data.
  task automatic send_pdu(input msfr_hdr_t h, input int n, input logic [DATA_W-1:0] base);
    int i;
    i = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      pduValid = 1'b1;
      pduFirst = (i == 0);
      pduLast = (i >= n - 1);
      pduHdr = h;
      pduHasData = (n > 0);
      pduData = base + 8'(37 * i);
      i++;
    end
    while (i < n);
    @(posedge core_clk);
    #1;
    pduValid = 1'b0;
    pduFirst = 1'b0;
    pduLast = 1'b0;
    pduHdr = ~h;
    pduData = ~pduData;
  endtask : send_pdu
endmodule : msfr_peer

// ### verif/tb_msfr_reassembly.sv
// Self-checking testbench for the MAC fragment reassembly block.
`timescale 1ns/100ps
module tb_msfr_reassembly
  import msfr_pkg::*;
;
  // Short timeout keeps the run brief; expectations derive from it.
  localparam int unsigned TMO = 20;
  localparam int CEIL = 4000;
  localparam logic NO = 1'b0;
  localparam logic YES = 1'b1;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pduValid, pduFirst, pduLast, pduHasData;
  msfr_hdr_t pduHdr, slotInfo;
  logic [DATA_W-1:0] pduData, sduData, b0, b1, b2;
  logic slotTick, decodeFail, grantIssued, waitIssued, grantCapacity, minModePin;
  msfr_mode_t modeCfg;
  logic sduValid, sduLast, sduDiscard, busy;
  logic [FRAME_W-1:0] curFrame;
  logic [SLOT_W-1:0] curSlot;
  logic [8:0] expQ[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cycleCnt = 0;
  integer seed = 32'h0000_4041;

  // Free-running 250 MHz clock.
  always #2 core_clk = ~core_clk;

  msfr_reassembly #(.TIMEOUT_CYCLES(TMO)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .pduValid(pduValid), .pduFirst(pduFirst), .pduLast(pduLast), .pduHdr(pduHdr),
    .pduData(pduData), .pduHasData(pduHasData), .slotTick(slotTick), .slotInfo(slotInfo),
    .decodeFail(decodeFail), .grantIssued(grantIssued), .waitIssued(waitIssued),
    .grantCapacity(grantCapacity), .minModePin(minModePin), .modeCfg(modeCfg),
    .sduValid(sduValid), .sduData(sduData), .sduLast(sduLast), .sduDiscard(sduDiscard), .busy(busy));

  msfr_peer u_peer (.core_clk(core_clk), .pduValid(pduValid), .pduFirst(pduFirst), .pduLast(pduLast),
    .pduHdr(pduHdr), .pduData(pduData), .pduHasData(pduHasData));

  // ********************
  // Helpers
  // ********************
  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [DATA_W-1:0] nb();
    return 8'($random(seed));
  endfunction : nb

  // Notes the bytes that one PDU carries, in arrival order.
  task automatic expect_bytes(input logic [DATA_W-1:0] base, input int n);
    for (int i = 0; i < n; i++)
      expQ.push_back({1'b0, base + 8'(37 * i)});
  endtask : expect_bytes

  // Builds a header for the current slot and hands it to the peer.
  task automatic send(input msfr_kind_t k, input logic fs, input logic sub, input int n,
    input logic [DATA_W-1:0] base);
    msfr_hdr_t h;
    h = '0;
    h.kind = k;
    h.fragStart = fs & ~modeCfg.downlink;
    h.lenInd = fs ? LEN_FRAG_START : 6'h05;
    h.addr = ADDR_W'($random(seed));
    h.ownAddr = 1'b1;
    h.granted = ~modeCfg.downlink;
    h.subslot = sub;
    h.slot = curSlot;
    h.frame = curFrame;
    u_peer.send_pdu(h, n, base);
  endtask : send

  // One slot event in the current frame and slot; a failed decode when fail is set.
  task automatic tick(input logic fail, input logic sub);
    @(posedge core_clk);
    #1;
    slotInfo.subslot = sub;
    slotInfo.frame = curFrame;
    slotInfo.slot = curSlot;
    slotTick = 1'b1;
    decodeFail = fail;
    @(posedge core_clk);
    #1;
    slotTick = 1'b0;
    decodeFail = 1'b0;
  endtask : tick

  // Waits, bounded, until every noted result has shown up, then watches for strays.
  task automatic drain();
    int w;
    w = 0;
    while (expQ.size() > 0 && w < 300)
    begin
      @(posedge core_clk);
      w++;
    end
    if (w >= 300)
    begin
      error_cnt++;
      $display("Error at %0t: expected results missing", $time);
      expQ.delete();
    end
    repeat (6) @(posedge core_clk);
    #1;
    check({8'h00, busy}, 9'h000);
  endtask : drain

  // ********************
  // Result watcher and watchdog
  // ********************
  // A discard is taken first, since it precedes delivery of a replacing PDU.
  always @(posedge core_clk)
  begin
    if (rst_n && sduDiscard === 1'b1)
      check(9'h100, expQ.size() > 0 ? expQ.pop_front() : 9'h000);
    if (rst_n && sduValid === 1'b1)
    begin
      check({1'b0, sduData}, expQ.size() > 0 ? expQ.pop_front() : 9'h100);
      check({8'h00, sduLast}, {8'h00, expQ.size() == 0});
    end
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk)
  begin
    cycleCnt++;
    if (cycleCnt >= CEIL)
    begin
      error_cnt++;
      $display("Error at %0t: cycle limit reached", $time);
      finish_test();
    end
  end

  // ********************
  // Scenarios
  // ********************
  initial
  begin
    slotTick = 1'b0;
    decodeFail = 1'b0;
    grantIssued = 1'b0;
    waitIssued = 1'b0;
    grantCapacity = 1'b1;
    minModePin = 1'b0;
    modeCfg = '0;
    modeCfg.commonCtrl = 1'b1;
    modeCfg.mySlot = 2'h1;
    slotInfo = '0;
    slotInfo.granted = 1'b1;
    slotInfo.ownAddr = 1'b1;
    curFrame = 5'h00;
    curSlot = 2'h0;
    repeat (5) @(posedge core_clk);
    #1;
    check({busy, sduValid, sduDiscard, 6'h00}, 9'h000);
    @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // Start without capacity, unfragmented data PDU, then orphan continuations of every kind.
    grantCapacity = 1'b0;
    send(MSFR_PDU_ACCESS, YES, NO, 1, nb());
    grantCapacity = 1'b1;
    b0 = nb();
    expect_bytes(b0, 3);
    send(MSFR_PDU_DATA, NO, NO, 3, b0);
    for (int k = 2; k < 5; k++)
      send(msfr_kind_t'(k), NO, k == 4, 2, nb());
    drain();
    // Start, two fragments and an empty end; nothing may leave before the end.
    b0 = nb();
    b1 = nb();
    b2 = nb();
    send(MSFR_PDU_ACCESS, YES, NO, 2, b0);
    send(MSFR_PDU_FRAG, NO, NO, 3, b1);
    send(MSFR_PDU_FRAG, NO, NO, 1, b2);
    expect_bytes(b0, 2);
    expect_bytes(b1, 3);
    expect_bytes(b2, 1);
    send(MSFR_PDU_END, NO, NO, 0, nb());
    drain();
    // Final subslot carrying an end-with-header PDU.
    b0 = nb();
    b1 = nb();
    send(MSFR_PDU_ACCESS, YES, NO, 2, b0);
    expect_bytes(b0, 2);
    expect_bytes(b1, 2);
    send(MSFR_PDU_ENDHU, NO, YES, 2, b1);
    drain();
    // Access PDU in the final subslot replaces the stored fragment.
    send(MSFR_PDU_ACCESS, YES, NO, 2, nb());
    b1 = nb();
    expQ.push_back(9'h100);
    expect_bytes(b1, 2);
    send(MSFR_PDU_ACCESS, NO, YES, 2, b1);
    drain();
    // Data PDU during reassembly discards the partial SDU and is then handled.
    send(MSFR_PDU_DATA, YES, NO, 2, nb());
    send(MSFR_PDU_FRAG, NO, NO, 1, nb());
    b1 = nb();
    expQ.push_back(9'h100);
    expect_bytes(b1, 2);
    send(MSFR_PDU_DATA, NO, NO, 2, b1);
    drain();
    // Decode failure in a granted slot blocks continuations until new data.
    send(MSFR_PDU_ACCESS, YES, NO, 2, nb());
    expQ.push_back(9'h100);
    tick(YES, NO);
    send(MSFR_PDU_FRAG, NO, NO, 2, nb());
    send(MSFR_PDU_END, NO, NO, 1, nb());
    b1 = nb();
    expect_bytes(b1, 1);
    send(MSFR_PDU_DATA, NO, NO, 1, b1);
    drain();
    // Undecodable final subslot.
    send(MSFR_PDU_ACCESS, YES, NO, 2, nb());
    expQ.push_back(9'h100);
    tick(YES, YES);
    drain();
    // Inactivity after the last grant; the discard must not come early.
    send(MSFR_PDU_ACCESS, YES, NO, 2, nb());
    expQ.push_back(9'h100);
    @(posedge core_clk);
    #1;
    // Either a grant or a wait order reloads the inactivity timer.
    {grantIssued, waitIssued} = 2'b01 << ($random(seed) & 1);
    @(posedge core_clk);
    #1;
    {grantIssued, waitIssued} = 2'b00;
    repeat (TMO - 2) @(posedge core_clk);
    check(9'(expQ.size()), 9'h001);
    drain();
    // Mobile in minimum mode: continuations only in its frame-18 slot.
    modeCfg.downlink = 1'b1;
    modeCfg.minMode = 1'b1;
    minModePin = 1'b1;
    repeat (4) @(posedge core_clk);
    b0 = nb();
    b1 = nb();
    b2 = nb();
    curFrame = FRAME_FIRST_NORMAL;
    curSlot = SLOT_ONE;
    send(MSFR_PDU_RESOURCE, YES, NO, 2, b0);
    curFrame = 5'h05;
    curSlot = modeCfg.mySlot;
    send(MSFR_PDU_FRAG, NO, NO, 2, nb());
    curFrame = FRAME_CTRL;
    expect_bytes(b0, 2);
    expect_bytes(b1, 1);
    send(MSFR_PDU_END, NO, NO, 1, b1);
    drain();
    // Frame-18 slots that pass without a fragment end the partial SDU, not earlier.
    curFrame = FRAME_FIRST_NORMAL;
    curSlot = SLOT_ONE;
    send(MSFR_PDU_RESOURCE, YES, NO, 1, nb());
    curFrame = FRAME_CTRL;
    curSlot = modeCfg.mySlot;
    expQ.push_back(9'h100);
    repeat (ABORT_COUNT_RST - 1) tick(NO, NO);
    @(posedge core_clk);
    #1;
    check(9'(expQ.size()), 9'h001);
    tick(NO, NO);
    drain();
    // A new start in slot 1 of a normal frame drops the partial SDU.
    curFrame = FRAME_FIRST_NORMAL;
    curSlot = SLOT_ONE;
    send(MSFR_PDU_RESOURCE, YES, NO, 1, nb());
    curFrame = FRAME_LAST_NORMAL;
    expQ.push_back(9'h100);
    send(MSFR_PDU_RESOURCE, YES, NO, 2, b2);
    curFrame = FRAME_CTRL;
    curSlot = modeCfg.mySlot;
    b1 = nb();
    expect_bytes(b2, 2);
    expect_bytes(b1, 1);
    send(MSFR_PDU_END, NO, NO, 1, b1);
    drain();
    // Out of minimum mode any slot carries continuations again.
    modeCfg.minMode = 1'b0;
    minModePin = 1'b0;
    repeat (4) @(posedge core_clk);
    curFrame = 5'h05;
    curSlot = 2'h2;
    b0 = nb();
    b1 = nb();
    send(MSFR_PDU_RESOURCE, YES, NO, 1, b0);
    expect_bytes(b0, 1);
    expect_bytes(b1, 2);
    send(MSFR_PDU_END, NO, NO, 2, b1);
    drain();
    finish_test();
  end
endmodule : tb_msfr_reassembly
